// ---- hdl/asmt_pkg.sv ----
`default_nettype none
package asmt_pkg;
  // ==========================================================
  // timer durations, in seconds
  localparam int unsigned RESTART_ACK_S    = 100;
  localparam int unsigned PEER_RESTART_S   = 120;
  localparam int unsigned CTRL_LOSS_A_S    = 15;
  localparam int unsigned CTRL_LOSS_B_S    = 60;
  localparam int unsigned PSTN_LOSS_S      = 15;
  localparam int unsigned FORCED_RESTART_S = 20;
  localparam int unsigned MIN_STOP_S       = 95;
  localparam int unsigned IDENT_CHECK_S    = 15;
  // counters run in tenths of a second, so the longest load needs 11 bits
  localparam int unsigned TICKS_PER_S      = 10;
  localparam int unsigned CNT_W            = 11;
  // ==========================================================
  // clock and timer count
  localparam int unsigned CLK_HZ           = 250_000_000;
  localparam int unsigned TIMER_COUNT      = 8;
  // ==========================================================
  // timer indices
  localparam int unsigned T_RACK  = 0;
  localparam int unsigned T_PEER  = 1;
  localparam int unsigned T_CLA   = 2;
  localparam int unsigned T_CLB   = 3;
  localparam int unsigned T_PLOSS = 4;
  localparam int unsigned T_FRST  = 5;
  localparam int unsigned T_MSTOP = 6;
  localparam int unsigned T_IDENT = 7;
  // ==========================================================
  // system states
  typedef enum logic [3:0] {
    ASMT_STARTUP  = 4'h0,
    ASMT_WAIT_ID  = 4'h1,
    ASMT_IN_SERV  = 4'h2,
    ASMT_CREL1    = 4'h3,
    ASMT_CREL2    = 4'h4,
    ASMT_FORCE    = 4'h7,
    ASMT_DEACTIVE = 4'h8
  } asmt_sys_t;
  localparam logic [1:0] PORT_BLOCKED     = 2'h1;
  localparam logic [1:0] PORT_OPERATIONAL = 2'h2;
endpackage
`default_nettype wire

// ---- hdl/asmt_timer_if.sv ----
`default_nettype none
interface asmt_timer_if #(parameter int unsigned N = 8);
  logic [N-1:0] start;
  logic [N-1:0] stop;
  logic [N-1:0] running;
  logic [N-1:0] expired;
  logic         tick;
  modport ctrl (output start, output stop, input running, input expired, input tick);
  modport bank (input start, input stop, output running, output expired, output tick);
endinterface
`default_nettype wire

// ---- hdl/asmt_tick.sv ----
`default_nettype none
module asmt_tick #(
  parameter int unsigned DIV = 250_000_000
) (
  input  wire logic CLK,
  input  wire logic NRST,
  output logic      tick
);
  logic [31:0] cnt_r;
  // one tick every DIV clocks; a DIV of one gives a tick on every edge
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_r == DIV - 1) begin
      cnt_r <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/asmt_timer_bank.sv ----
`default_nettype none
module asmt_timer_bank #(
  parameter int unsigned N = 8,
  parameter int unsigned W = 8,
  parameter logic [N*W-1:0] LOADS = '0
) (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       tick,
  asmt_timer_if.bank      tif
);
  assign tif.tick = tick;
  // ==========================================================
  // one down counter per timer; start wins over stop and reloads
  for (genvar i = 0; i < N; i++) begin : g_tmr
    logic [W-1:0] cnt_r;
    logic         run_r;
    logic         exp_r;
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        cnt_r <= '0;
        run_r <= 1'b0;
        exp_r <= 1'b0;
      end else begin
        exp_r <= 1'b0;
        if (tif.start[i]) begin
          cnt_r <= LOADS[i*W +: W];
          run_r <= 1'b1;
        end else if (tif.stop[i]) begin
          run_r <= 1'b0;
        end else if (run_r && tick) begin
          if (cnt_r <= W'(1)) begin
            run_r <= 1'b0;
            exp_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - W'(1);
          end
        end
      end
    end
    assign tif.running[i] = run_r;
    assign tif.expired[i] = exp_r;
  end
endmodule
`default_nettype wire

// ---- hdl/asmt_top.sv ----
`default_nettype none
// Behaviour
// - every timer expires within five percent of its nominal value
// - restart requests to protocol machines start 100 s ack timer; expiry abandons
// - restart request to or from common control starts 2 min peer timer
// - control link release runs 15 s then 1 min then forced restart
// - phone link release starts 15 s timer; expiry blocks all phone ports
// - forced restart 20 s timer never stopped early; expiry starts system
// - minimum stop 95 s timer starts whenever stopped, always runs out
// - power up runs minimum stop timer before system start-up
// - layer 1 failure notice to both links on loss, internal failure, stop request
// - layer 1 deactivation starts minimum stop and enters forced restart
// - stop request: links down, stop traffic, block ports, minimum stop, force
// - forced restart or minimum stop expiry: start up if wanted, else deactive
// - identity request starts 15 s identity check timer in wait and service
// - first identity expiry resends the request and restarts timer
// - second expiry raises error, then repeats check or forces restart
// - identity response stops the identity check timer
// - port operational to blocked sends port blocked primitive
// - port entering operational sends port unblocked primitive
module asmt_top #(
  parameter int unsigned CLK_HZ = asmt_pkg::CLK_HZ,
  parameter int unsigned PORTS  = 4
) (
  input  wire logic               CLK,
  input  wire logic               NRST,
  input  wire logic               CTRL_LINK_RELEASED,
  input  wire logic               CTRL_LINK_UP_CONFIRM,
  input  wire logic               CTRL_LINK_UP_NOTICE,
  input  wire logic               PHONE_LINK_RELEASED,
  input  wire logic               PHONE_LINK_UP,
  input  wire logic               LAYER1_DEACTIVATED_IND,
  input  wire logic               INTERNAL_FAILURE,
  input  wire logic               STOP_REQ,
  input  wire logic               RESTART_WANTED,
  input  wire logic               IDENT_RETRY_PERIODIC,
  input  wire logic               PEER_RESTART_REQ,
  input  wire logic               LOCAL_RESTART_REQ,
  input  wire logic               PEER_RESTART_DONE,
  input  wire logic               PROTO_RESTART_ACK_ALL,
  input  wire logic               IDENT_RESP,
  input  wire logic [2*PORTS-1:0] PORT_STATE,
  output logic                    SYS_STARTUP,
  output logic                    CTRL_LINK_ESTABLISH_REQ,
  output logic                    LAYER1_FAILURE_NOTICE,
  output logic                    STOP_TRAFFIC,
  output logic                    BLOCK_ALL_PORTS,
  output logic                    BLOCK_PHONE_PORTS,
  output logic                    RESTART_REQ_TO_PROTO,
  output logic                    RESTART_REQ_TO_PEER,
  output logic                    RESTART_DONE_TO_PROTO,
  output logic                    RESTART_DONE_TO_PEER,
  output logic                    RESTART_ABANDON,
  output logic                    IDENT_REQ,
  output logic                    MGMT_ERROR,
  output logic [PORTS-1:0]        PORT_BLOCK_CMD,
  output logic [PORTS-1:0]        PORT_UNBLOCK_CMD,
  output logic [3:0]              SYS_STATE
);
  localparam int unsigned N = asmt_pkg::TIMER_COUNT;
  localparam int unsigned W = asmt_pkg::CNT_W;
  localparam int unsigned TPS = asmt_pkg::TICKS_PER_S;
  // tenth-second loads
  // a timer starts anywhere inside a tick period, so it may lose up to one tick;
  // a tenth of a second on the 15 s timers stays under one percent, where a
  // whole-second tick would lose almost seven
  localparam logic [N*W-1:0] LOADS = {
    W'(asmt_pkg::IDENT_CHECK_S * TPS),    W'(asmt_pkg::MIN_STOP_S * TPS),
    W'(asmt_pkg::FORCED_RESTART_S * TPS), W'(asmt_pkg::PSTN_LOSS_S * TPS),
    W'(asmt_pkg::CTRL_LOSS_B_S * TPS),    W'(asmt_pkg::CTRL_LOSS_A_S * TPS),
    W'(asmt_pkg::PEER_RESTART_S * TPS),   W'(asmt_pkg::RESTART_ACK_S * TPS)};

  asmt_timer_if #(.N(N)) tif ();
  logic tick;

  // ==========================================================
  // shared tick and timers
  // shared prescaled tick
  // CLK_HZ must be a multiple of TPS, or every tick period comes out short
  asmt_tick #(.DIV(CLK_HZ / TPS)) u_tick (
    .CLK  (CLK),
    .NRST (NRST),
    .tick (tick)
  );
  asmt_timer_bank #(.N(N), .W(W), .LOADS(LOADS)) u_bank (
    .CLK  (CLK),
    .NRST (NRST),
    .tick (tick),
    .tif  (tif)
  );

  asmt_pkg::asmt_sys_t sys_r;
  asmt_pkg::asmt_sys_t sys_nxt;
  logic [N-1:0] start_c;
  logic [N-1:0] stop_c;
  logic         rst_done_r;
  logic         ident_second_r;
  logic         rs_active_r;
  logic         peer_done_r;
  logic         proto_done_r;
  logic         ctrl_up;
  logic         stop_evt;
  logic         frst_or_mstop_exp;
  logic         startup_c;

  // a confirm and a notice both mean the control link is up
  assign ctrl_up  = CTRL_LINK_UP_CONFIRM | CTRL_LINK_UP_NOTICE;
  // persistent identity failure may force restart
  assign stop_evt = STOP_REQ | INTERNAL_FAILURE |
                    (tif.expired[asmt_pkg::T_IDENT] && ident_second_r &&
                     !IDENT_RETRY_PERIODIC);
  // while the forced-restart timer runs, a minimum-stop expiry is left to it
  assign frst_or_mstop_exp = tif.expired[asmt_pkg::T_FRST] |
                             (tif.expired[asmt_pkg::T_MSTOP] &&
                              !tif.running[asmt_pkg::T_FRST]);
  assign startup_c = (sys_r == asmt_pkg::ASMT_FORCE) && frst_or_mstop_exp &&
                     RESTART_WANTED;

  // ==========================================================
  // system state machine
  always_comb begin
    sys_nxt = sys_r;
    unique case (sys_r)
      asmt_pkg::ASMT_STARTUP:
        if (ctrl_up) sys_nxt = asmt_pkg::ASMT_WAIT_ID;
      asmt_pkg::ASMT_WAIT_ID:
        if (IDENT_RESP) sys_nxt = asmt_pkg::ASMT_IN_SERV;
      asmt_pkg::ASMT_IN_SERV:
        if (CTRL_LINK_RELEASED) sys_nxt = asmt_pkg::ASMT_CREL1;
      asmt_pkg::ASMT_CREL1:
        if (ctrl_up) sys_nxt = asmt_pkg::ASMT_IN_SERV;
        else if (tif.expired[asmt_pkg::T_CLA]) sys_nxt = asmt_pkg::ASMT_CREL2;
      asmt_pkg::ASMT_CREL2:
        if (ctrl_up) sys_nxt = asmt_pkg::ASMT_IN_SERV;
        else if (tif.expired[asmt_pkg::T_CLB]) sys_nxt = asmt_pkg::ASMT_FORCE;
      asmt_pkg::ASMT_FORCE:
        if (frst_or_mstop_exp)
          sys_nxt = RESTART_WANTED ? asmt_pkg::ASMT_STARTUP : asmt_pkg::ASMT_DEACTIVE;
      asmt_pkg::ASMT_DEACTIVE:
        if (RESTART_WANTED) sys_nxt = asmt_pkg::ASMT_STARTUP;
      default: sys_nxt = asmt_pkg::ASMT_FORCE;
    endcase
    if (LAYER1_DEACTIVATED_IND || stop_evt) sys_nxt = asmt_pkg::ASMT_FORCE;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) sys_r <= asmt_pkg::ASMT_FORCE;
    else       sys_r <= sys_nxt;
  end

  // ==========================================================
  // timer starts and stops
  always_comb begin
    start_c = '0;
    stop_c  = '0;
    // minimum stop start
    // rst_done_r is low only on the first edge after reset, so power up counts as a stop
    start_c[asmt_pkg::T_MSTOP] = !rst_done_r || LAYER1_DEACTIVATED_IND || stop_evt;
    start_c[asmt_pkg::T_CLA] = (sys_r == asmt_pkg::ASMT_IN_SERV) && CTRL_LINK_RELEASED;
    start_c[asmt_pkg::T_CLB] = (sys_r == asmt_pkg::ASMT_CREL1) &&
                               tif.expired[asmt_pkg::T_CLA] && !ctrl_up;
    stop_c[asmt_pkg::T_CLA]  = ctrl_up;
    stop_c[asmt_pkg::T_CLB]  = ctrl_up;
    start_c[asmt_pkg::T_FRST] = (sys_r == asmt_pkg::ASMT_CREL2) &&
                                tif.expired[asmt_pkg::T_CLB] && !ctrl_up;
    start_c[asmt_pkg::T_PLOSS] = PHONE_LINK_RELEASED && !tif.running[asmt_pkg::T_PLOSS];
    stop_c[asmt_pkg::T_PLOSS]  = PHONE_LINK_UP;
    start_c[asmt_pkg::T_RACK] = !rs_active_r && (PEER_RESTART_REQ || LOCAL_RESTART_REQ);
    start_c[asmt_pkg::T_PEER] = start_c[asmt_pkg::T_RACK];
    stop_c[asmt_pkg::T_RACK]  = PROTO_RESTART_ACK_ALL;
    stop_c[asmt_pkg::T_PEER]  = PEER_RESTART_DONE;
    start_c[asmt_pkg::T_IDENT] = IDENT_REQ;
    stop_c[asmt_pkg::T_IDENT]  = IDENT_RESP ||
                                 !(sys_r == asmt_pkg::ASMT_WAIT_ID ||
                                   sys_r == asmt_pkg::ASMT_IN_SERV);
  end
  assign tif.start = start_c;
  assign tif.stop  = stop_c;

  // ==========================================================
  // event outputs
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_done_r              <= 1'b0;
      SYS_STARTUP             <= 1'b0;
      CTRL_LINK_ESTABLISH_REQ <= 1'b0;
      LAYER1_FAILURE_NOTICE   <= 1'b0;
      STOP_TRAFFIC            <= 1'b0;
      BLOCK_ALL_PORTS         <= 1'b0;
      BLOCK_PHONE_PORTS       <= 1'b0;
    end else begin
      rst_done_r              <= 1'b1;
      SYS_STARTUP             <= startup_c;
      CTRL_LINK_ESTABLISH_REQ <= startup_c;
      LAYER1_FAILURE_NOTICE   <= LAYER1_DEACTIVATED_IND | stop_evt;
      STOP_TRAFFIC            <= stop_evt;
      BLOCK_ALL_PORTS         <= stop_evt;
      BLOCK_PHONE_PORTS       <= tif.expired[asmt_pkg::T_PLOSS] | stop_evt;
    end
  end

  // identity check sequencing
  // ident_second_r flips on each expiry, so periodic retry resends on every expiry and raises error on every second one
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IDENT_REQ      <= 1'b0;
      ident_second_r <= 1'b0;
      MGMT_ERROR     <= 1'b0;
    end else begin
      IDENT_REQ  <= (sys_r == asmt_pkg::ASMT_STARTUP && ctrl_up) ||
                    (tif.expired[asmt_pkg::T_IDENT] && (!ident_second_r ||
                     IDENT_RETRY_PERIODIC));
      MGMT_ERROR <= (tif.expired[asmt_pkg::T_IDENT] && ident_second_r) ||
                    (rs_active_r && (tif.expired[asmt_pkg::T_RACK] ||
                                     tif.expired[asmt_pkg::T_PEER]));
      if (IDENT_RESP || (sys_r == asmt_pkg::ASMT_STARTUP && ctrl_up))
        ident_second_r <= 1'b0;
      else if (tif.expired[asmt_pkg::T_IDENT])
        ident_second_r <= !ident_second_r;
    end
  end

  // ==========================================================
  // phone restart process
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rs_active_r           <= 1'b0;
      peer_done_r           <= 1'b0;
      proto_done_r          <= 1'b0;
      RESTART_REQ_TO_PROTO  <= 1'b0;
      RESTART_REQ_TO_PEER   <= 1'b0;
      RESTART_DONE_TO_PROTO <= 1'b0;
      RESTART_DONE_TO_PEER  <= 1'b0;
      RESTART_ABANDON       <= 1'b0;
    end else begin
      RESTART_REQ_TO_PROTO  <= start_c[asmt_pkg::T_RACK];
      RESTART_REQ_TO_PEER   <= !rs_active_r && LOCAL_RESTART_REQ && !PEER_RESTART_REQ;
      RESTART_DONE_TO_PROTO <= 1'b0;
      RESTART_DONE_TO_PEER  <= 1'b0;
      RESTART_ABANDON       <= 1'b0;
      // a request that arrives while a restart runs is dropped, not queued
      if (start_c[asmt_pkg::T_RACK]) begin
        rs_active_r  <= 1'b1;
        peer_done_r  <= 1'b0;
        proto_done_r <= 1'b0;
      end else if (rs_active_r) begin
        // ack or expiry closes local side
        if ((PROTO_RESTART_ACK_ALL && tif.running[asmt_pkg::T_RACK]) ||
            tif.expired[asmt_pkg::T_RACK]) begin
          proto_done_r         <= 1'b1;
          RESTART_DONE_TO_PEER <= 1'b1;
          RESTART_ABANDON      <= tif.expired[asmt_pkg::T_RACK];
        end
        if (PEER_RESTART_DONE && tif.running[asmt_pkg::T_PEER])
          peer_done_r <= 1'b1;
        if (tif.expired[asmt_pkg::T_PEER] || (peer_done_r && proto_done_r)) begin
          rs_active_r           <= 1'b0;
          RESTART_DONE_TO_PROTO <= 1'b1;
          RESTART_ABANDON       <= tif.expired[asmt_pkg::T_PEER];
        end
      end
    end
  end

  // ==========================================================
  // port blocking alignment, one lane per port
  // prev_r resets to blocked, so a port already operational when reset ends
  // is sent one unblock; harmless, and it aligns the protocol side at start
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [1:0] prev_r;
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        prev_r              <= asmt_pkg::PORT_BLOCKED;
        PORT_BLOCK_CMD[p]   <= 1'b0;
        PORT_UNBLOCK_CMD[p] <= 1'b0;
      end else begin
        prev_r <= PORT_STATE[2*p +: 2];
        PORT_BLOCK_CMD[p] <= (prev_r == asmt_pkg::PORT_OPERATIONAL) &&
                             (PORT_STATE[2*p +: 2] == asmt_pkg::PORT_BLOCKED);
        PORT_UNBLOCK_CMD[p] <= (prev_r != asmt_pkg::PORT_OPERATIONAL) &&
                               (PORT_STATE[2*p +: 2] == asmt_pkg::PORT_OPERATIONAL);
      end
    end
  end

  assign SYS_STATE = sys_r;
endmodule
`default_nettype wire

// ---- test/asmt_chk.sv ----
`default_nettype none
module asmt_chk #(
  parameter int unsigned CLK_HZ = 10,
  parameter int unsigned PORTS  = 4
) (
  input wire logic               CLK,
  input wire logic               NRST,
  input wire logic               CTRL_LINK_RELEASED,
  input wire logic               CTRL_LINK_UP_CONFIRM,
  input wire logic               LAYER1_DEACTIVATED_IND,
  input wire logic               STOP_REQ,
  input wire logic               IDENT_RESP,
  input wire logic [2*PORTS-1:0] PORT_STATE,
  input wire logic               SYS_STARTUP,
  input wire logic               LAYER1_FAILURE_NOTICE,
  input wire logic               STOP_TRAFFIC,
  input wire logic               BLOCK_ALL_PORTS,
  input wire logic               IDENT_REQ,
  input wire logic [PORTS-1:0]   PORT_BLOCK_CMD,
  input wire logic [PORTS-1:0]   PORT_UNBLOCK_CMD,
  input wire logic [3:0]         SYS_STATE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // cycles in forced restart; 32 bits only suit a scaled-down clock rate
  logic [31:0] f_r;
  logic [31:0] f_nxt;
  assign f_nxt = (SYS_STATE == 4'h7) ? f_r + 32'h1 : 32'h0;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      f_r <= 32'h0;
    end else begin
      f_r <= f_nxt;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  AST_PBLK: assert property (
    $past(PORT_STATE[1:0]) == 2'h2 && PORT_STATE[1:0] == 2'h1 |-> ##1 PORT_BLOCK_CMD[0])
    else $error("port block command missing");
  AST_PUBL: assert property (
    PORT_STATE[1:0] == 2'h2 && $past(PORT_STATE[1:0]) != 2'h2 |-> ##1 PORT_UNBLOCK_CMD[0])
    else $error("port unblock command missing");
  AST_IDRQ: assert property (
    SYS_STATE == 4'h0 && CTRL_LINK_UP_CONFIRM |-> ##1 IDENT_REQ && SYS_STATE == 4'h1)
    else $error("identity request missing");
  AST_IDRS: assert property (
    SYS_STATE == 4'h1 && IDENT_RESP |-> ##1 SYS_STATE == 4'h2)
    else $error("identity response not taken");
  AST_CREL: assert property (
    SYS_STATE == 4'h2 && CTRL_LINK_RELEASED |-> ##1 SYS_STATE == 4'h3)
    else $error("control release not taken");
  AST_L1: assert property (
    LAYER1_DEACTIVATED_IND |-> ##1 LAYER1_FAILURE_NOTICE && SYS_STATE == 4'h7)
    else $error("layer1 loss not handled");
  AST_STOP: assert property (
    STOP_REQ && SYS_STATE == 4'h2 |-> ##1 STOP_TRAFFIC && BLOCK_ALL_PORTS && SYS_STATE == 4'h7)
    else $error("stop not handled");
  AST_SUP: assert property (
    SYS_STARTUP |-> SYS_STATE == 4'h0 && $past(SYS_STATE) == 4'h7)
    else $error("startup outside forced restart exit");
  AST_FMIN: assert property (
    $past(SYS_STATE) == 4'h7 && SYS_STATE != 4'h7 |-> f_r >= 19 * CLK_HZ)
    else $error("forced restart left early");
  AST_FMAX: assert property (
    SYS_STATE == 4'h7 |-> f_r <= 96 * CLK_HZ + 4)
    else $error("forced restart overstayed");
  cover property (SYS_STARTUP);
  cover property (PORT_BLOCK_CMD[0]);
  cover property (STOP_TRAFFIC);
endmodule
bind asmt_top asmt_chk #(.CLK_HZ(CLK_HZ), .PORTS(PORTS)) u_chk (
  .CLK, .NRST, .CTRL_LINK_RELEASED, .CTRL_LINK_UP_CONFIRM, .LAYER1_DEACTIVATED_IND,
  .STOP_REQ, .IDENT_RESP, .PORT_STATE, .SYS_STARTUP, .LAYER1_FAILURE_NOTICE,
  .STOP_TRAFFIC, .BLOCK_ALL_PORTS, .IDENT_REQ, .PORT_BLOCK_CMD, .PORT_UNBLOCK_CMD,
  .SYS_STATE
);
`default_nettype wire

// ---- test/asmt_peer.sv ----
`default_nettype none
module asmt_peer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       est_req,
  input  wire logic       id_req,
  input  wire logic       id_en,
  input  wire logic [3:0] dly,
  output logic            up_cfm,
  output logic            id_resp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // link entity and common control, both answering dly cycles late
  logic [3:0] lc_r;
  logic [3:0] ic_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lc_r   <= 4'h0;
      up_cfm <= 1'b0;
    end else begin
      up_cfm <= (lc_r == 4'h1);
      if (est_req) begin
        lc_r <= dly;
      end else if (lc_r != 4'h0) begin
        lc_r <= lc_r - 4'h1;
      end
    end
  end
  // a silent common control (id_en low) is what drives the retry paths
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ic_r    <= 4'h0;
      id_resp <= 1'b0;
    end else begin
      id_resp <= (ic_r == 4'h1);
      if (id_req && id_en) begin
        ic_r <= dly;
      end else if (ic_r != 4'h0) begin
        ic_r <= ic_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/test_asmt_top.sv ----
`default_nettype none
module test_asmt_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        nrst;
  logic [12:0] ev;
  logic [7:0]  ps;
  logic        id_en;
  logic [3:0]  dly;
  wire         cfm;
  wire         idr;
  wire  [12:0] ov;
  wire  [3:0]  pb;
  wire  [3:0]  pu;
  wire  [3:0]  st;
  int          n_fail;
  int          check_count;
  // one second is ten cycles here
  asmt_top #(.CLK_HZ(10), .PORTS(4)) dut (
    .CLK(clk), .NRST(nrst), .CTRL_LINK_RELEASED(ev[0]), .CTRL_LINK_UP_CONFIRM(cfm),
    .CTRL_LINK_UP_NOTICE(ev[1]), .PHONE_LINK_RELEASED(ev[2]), .PHONE_LINK_UP(ev[3]),
    .LAYER1_DEACTIVATED_IND(ev[4]), .INTERNAL_FAILURE(ev[5]), .STOP_REQ(ev[6]),
    .RESTART_WANTED(ev[7]), .IDENT_RETRY_PERIODIC(ev[8]), .PEER_RESTART_REQ(ev[9]),
    .LOCAL_RESTART_REQ(ev[10]), .PEER_RESTART_DONE(ev[11]), .PROTO_RESTART_ACK_ALL(ev[12]),
    .IDENT_RESP(idr), .PORT_STATE(ps), .SYS_STARTUP(ov[0]), .CTRL_LINK_ESTABLISH_REQ(ov[1]),
    .LAYER1_FAILURE_NOTICE(ov[2]), .STOP_TRAFFIC(ov[3]), .BLOCK_ALL_PORTS(ov[4]),
    .BLOCK_PHONE_PORTS(ov[5]), .RESTART_REQ_TO_PROTO(ov[6]), .RESTART_REQ_TO_PEER(ov[7]),
    .RESTART_DONE_TO_PROTO(ov[8]), .RESTART_DONE_TO_PEER(ov[9]), .RESTART_ABANDON(ov[10]),
    .IDENT_REQ(ov[11]), .MGMT_ERROR(ov[12]), .PORT_BLOCK_CMD(pb), .PORT_UNBLOCK_CMD(pu),
    .SYS_STATE(st));
  asmt_peer peer (.clk(clk), .nrst(nrst), .est_req(ov[1]), .id_req(ov[11]), .id_en(id_en),
    .dly(dly), .up_cfm(cfm), .id_resp(idr));
  // ==========
  // shared tasks
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask
  // k below 16 is an output bit, from 16 up a state value
  task automatic wt(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (!(k < 16 ? ov[k] === 1'b1 : st === 4'(k - 16)) && c < lim);
  endtask
  task automatic wr(input int k, input int lo, input int hi);
    int c;
    wt(k, hi + 1, c);
    chk({3'h0, c >= lo && c <= hi}, 4'h1);
  endtask
  task automatic setp(input logic [7:0] v, input logic [3:0] b, input logic [3:0] u);
    @(posedge clk);
    ps <= v;
    @(posedge clk);
    @(negedge clk);
    chk(pb, b);
    chk(pu, u);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_power();
    wr(0, 935, 965);
    wr(11, 1, 12);
    wr(11, 140, 160);
    @(posedge clk);
    id_en <= 1'b1;
    wr(12, 135, 160);
    wr(18, 1, 170);
    $display("power done");
  endtask
  task automatic t_ports();
    setp(8'ha9, 4'h1, 4'h0);
    setp(8'h69, 4'h8, 4'h0);
    setp(8'h6a, 4'h0, 4'h1);
    setp(8'haa, 4'h0, 4'h8);
    setp(8'haa, 4'h0, 4'h0);
    $display("ports done");
  endtask
  task automatic t_restart();
    pulse(10);
    @(negedge clk);
    chk({2'h0, ov[7:6]}, 4'h3);
    pulse(12);
    wr(9, 1, 2);
    wr(10, 1180, 1215);
    chk({3'h0, ov[8]}, 4'h1);
    pulse(9);
    wr(12, 985, 1012);
    wr(10, 1, 230);
    // both sides complete in time: close without abandon
    pulse(9);
    pulse(12);
    pulse(11);
    wr(8, 1, 3);
    chk({3'h0, ov[10]}, 4'h0);
    $display("restart done");
  endtask
  task automatic t_phone();
    int c;
    pulse(2);
    wr(5, 140, 160);
    pulse(2);
    repeat (50) @(posedge clk);
    pulse(3);
    wt(5, 200, c);
    chk({3'h0, ov[5]}, 4'h0);
    $display("phone done");
  endtask
  task automatic t_ctrl();
    int c;
    dly <= 4'h9;
    pulse(0);
    @(negedge clk);
    chk(st, 4'h3);
    wr(20, 140, 160);
    wr(23, 590, 612);
    wr(0, 190, 212);
    wr(18, 1, 60);
    pulse(0);
    repeat (20) @(posedge clk);
    pulse(1);
    wt(20, 200, c);
    chk(st, 4'h2);
    $display("ctrl done");
  endtask
  task automatic t_stop();
    ev[7] <= 1'b0;
    pulse(6);
    @(negedge clk);
    chk({2'h0, ov[4:3]}, 4'h3);
    chk(st, 4'h7);
    wr(24, 935, 965);
    ev[7] <= 1'b1;
    pulse(4);
    @(negedge clk);
    chk({3'h0, ov[2]}, 4'h1);
    chk(st, 4'h7);
    wr(0, 935, 965);
    wr(18, 1, 60);
    pulse(5);
    wr(2, 1, 3);
    // silent common control and no periodic retry: second expiry forces restart
    @(posedge clk);
    id_en <= 1'b0;
    ev[8] <= 1'b0;
    wr(0, 935, 965);
    wr(12, 300, 330);
    chk(st, 4'h7);
    chk({3'h0, ov[3]}, 4'h1);
    $display("stop done");
  endtask
  initial begin
    nrst        = 1'b0;
    ev          = 13'h180;
    ps          = 8'haa;
    id_en       = 1'b0;
    dly         = 4'h3;
    n_fail      = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_power();
    t_ports();
    t_restart();
    t_phone();
    t_ctrl();
    t_stop();
    results();
  end
  // the tests need about 34 us; allow well over twice that
  initial begin
    #100000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
